// file: rtl/ced_engine.sv
// instruction engine of the character display controller
// Operation
// - clear fills spaces, homes, sets increment
// - home zeroes counter and shift, keeps text
// - direction bit picks counter step
// - auto shift on text writes only
// - glyph accesses step like text accesses
// - display enable blanks, keeps text RAM
// - cursor enable keeps direction bit
// - blink alternates solid cell and character
// - shift decodes cursor or display moves
// - display shift keeps counter and RAM
// - two-line cursor wraps to second line
// - width bit picks 8 or 4-bit
// - line bit picks one or two lines
// - font bit picks 5x8 or 5x11
// - glyph address set loads six bits
// - text address set loads seven bits
// - one-line text addresses 00H to 4FH
// - two-line ranges 00H-27H and 40H-67H
// - status read gives busy and counter
// - data write stores, then counter steps
// - prefetch loaded by address set, text cursor shift
// - read after write returns old prefetch
// - busy held through internal operation
// - execution times 1.53ms, 39us, 43us
`timescale 1ns/100ps
`default_nettype none
module ced_engine
  import ced_pkg::*;
#(
  parameter int CLR_CYC   = ced_cyc(CLR_NS),
  parameter int DAT_CYC   = ced_cyc(DAT_NS),
  parameter int BLINK_CYC = ced_cyc(BLINK_NS)
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // host pins
  input  wire logic       register_select_line,
  input  wire logic       rw,
  input  wire logic       en,
  input  wire logic [7:0] db_i,
  output logic      [7:0] db_o,
  output logic            db_oe_n,
  // panel scan side
  input  wire logic [6:0] scan_addr,
  output logic      [7:0] scan_char,
  input  wire logic [5:0] glyph_addr,
  output logic      [7:0] glyph_row,
  // state shown to the panel
  output ced_cfg_t        cfg,
  output logic      [6:0] shift_ofs,
  output logic      [6:0] cursor_addr,
  output logic            cursor_solid,
  output logic            glyph_sel,
  output logic            internal_busy_flag
);
  // next counter value, wrapping inside the valid ranges
  function automatic logic [6:0] ac_next(input logic [6:0] a,
      input logic up, input logic two, input logic cg);
    logic [6:0] r;
    r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (cg) begin
      r = {1'b0, r[5:0]};
    end else if (!two) begin
      if (up && a == L1_LAST) r = AC_HOME;
      if (!up && a == AC_HOME) r = L1_LAST;
    end else begin
      if (up && a == L2A_LAST) r = L2B_FIRST;
      if (up && a == L2B_LAST) r = AC_HOME;
      if (!up && a == L2B_FIRST) r = L2A_LAST;
      if (!up && a == AC_HOME) r = L2B_LAST;
    end
    return r;
  endfunction : ac_next

  // next display shift offset, lines move together
  function automatic logic [6:0] ofs_next(input logic [6:0] o,
      input logic left, input logic two);
    logic [6:0] lim;
    lim = two ? L2A_LAST : L1_LAST;
    if (left) begin
      return (o >= lim) ? AC_HOME : 7'(o + 7'h01);
    end
    return (o == AC_HOME) ? lim : 7'(o - 7'h01);
  endfunction : ofs_next

  ced_state_t  st_q;
  ced_cfg_t    cfg_q;
  logic [6:0]  ac_q;
  logic [6:0]  ofs_q;
  logic        incr_q;
  logic        ash_q;
  logic        cg_q;
  logic [7:0]  pf_q;
  logic        pf_ld_q;
  logic [6:0]  fill_q;
  logic [BW-1:0] cnt_q;
  logic [31:0] blk_cnt_q;
  logic        blk_q;
  logic        xfer_v;
  ced_xfer_t   xfer;
  logic        rd_v;
  logic        rd_rs;
  logic [7:0]  dd_rd;
  logic [7:0]  cg_rd;

  // decode by top set bit of an instruction write
  wire  [7:0] d       = xfer.data;
  wire        idle    = (st_q == ST_IDLE);
  wire        go      = xfer_v & idle;
  wire        ins     = go & ~xfer.rs;
  wire        is_dd   = ins & d[7];
  wire        is_cg   = ins & (d[7:6] == 2'b01);
  wire        is_fn   = ins & (d[7:5] == 3'b001);
  wire        is_sh   = ins & (d[7:4] == 4'b0001);
  wire        is_dc   = ins & (d[7:3] == 5'b00001);
  wire        is_em   = ins & (d[7:2] == 6'b000001);
  wire        is_home = ins & (d[7:1] == 7'b0000001);
  wire        is_clr  = ins & (d == 8'h01);
  wire        dwr     = go & xfer.rs;
  wire        drd     = rd_v & rd_rs & idle;
  wire        sh_cur  = is_sh & ~d[B_SC];
  wire        sh_dsp  = is_sh & d[B_SC];
  wire        any_op  = (ins & (d != 8'h00)) | dwr | drd;
  wire        long_op = is_clr | is_home;
  wire        data_op = dwr | drd;
  wire        filling = (st_q == ST_FILL);
  wire        dd_we   = filling | (dwr & ~cg_q);
  wire  [6:0] dd_wa   = filling ? fill_q : ac_q;
  wire  [7:0] dd_wd   = filling ? SPACE_CODE : d;
  wire        cg_we   = dwr & cg_q;
  wire  [6:0] ac_step = ac_next(ac_q, incr_q, cfg_q.two_line, cg_q);
  wire  [7:0] stat    = {~idle, ac_q};

  // host pin front end
  ced_port u_port (
    .mclk                 (mclk),
    .srst                 (srst),
    .register_select_line (register_select_line),
    .rw                   (rw),
    .en                   (en),
    .db_i                 (db_i),
    .db_o                 (db_o),
    .db_oe_n              (db_oe_n),
    .bus8                 (cfg_q.bus_width_select),
    .stat_byte            (stat),
    .data_byte            (pf_q),
    .xfer_v               (xfer_v),
    .xfer                 (xfer),
    .rd_v                 (rd_v),
    .rd_rs                (rd_rs)
  );

  // text RAM, second port feeds the panel scan
  ced_ram #(.AW(DD_AW)) u_dd (
    .mclk (mclk),
    .we   (dd_we),
    .wa   (dd_wa),
    .wd   (dd_wd),
    .ra0  (ac_q),
    .rd0  (dd_rd),
    .ra1  (scan_addr),
    .rd1  (scan_char)
  );

  // glyph RAM, second port feeds the glyph generator
  ced_ram #(.AW(CG_AW)) u_cg (
    .mclk (mclk),
    .we   (cg_we),
    .wa   (ac_q[5:0]),
    .wd   (d),
    .ra0  (ac_q[5:0]),
    .rd0  (cg_rd),
    .ra1  (glyph_addr),
    .rd1  (glyph_row)
  );

  // busy sequencing: fill, then wait out the execution time
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q   <= ST_IDLE;
      cnt_q  <= '0;
      fill_q <= AC_HOME;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (any_op) begin
            st_q  <= is_clr ? ST_FILL : ST_BUSY;
            fill_q <= AC_HOME;
            cnt_q <= long_op ? BW'(CLR_CYC - 1) :
                     data_op ? BW'(DAT_CYC - 1) : BW'(INS_CYC - 1);
          end
        end
        ST_FILL: begin
          cnt_q  <= cnt_q - 1'b1;
          fill_q <= 7'(fill_q + 7'h01);
          if (fill_q == FILL_LAST) st_q <= ST_BUSY;
        end
        ST_BUSY: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == '0) st_q <= ST_IDLE;
        end
        // unused code falls back to idle
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // configuration bits from instruction writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_q  <= CFG_RST;
      incr_q <= 1'b1;
      ash_q  <= 1'b0;
    end else begin
      if (is_clr) incr_q <= 1'b1;
      if (is_em) begin
        incr_q <= d[B_ID];
        ash_q  <= d[B_SH];
      end
      if (is_dc) begin
        cfg_q.disp_on   <= d[B_D];
        cfg_q.cursor_on <= d[B_C];
        cfg_q.blink_on  <= d[B_B];
      end
      if (is_fn) begin
        cfg_q.bus_width_select <= d[B_DL];
        cfg_q.two_line         <= d[B_N];
        cfg_q.font_5x11        <= d[B_F];
      end
    end
  end

  // address counter, RAM select and display shift
  always_ff @(posedge mclk) begin
    if (srst) begin
      ac_q  <= AC_HOME;
      ofs_q <= AC_HOME;
      cg_q  <= 1'b0;
    end else begin
      if (is_clr || is_home) begin
        ac_q  <= AC_HOME;
        ofs_q <= AC_HOME;
        cg_q  <= 1'b0;
      end
      if (is_cg) begin
        ac_q <= {1'b0, d[5:0]};
        cg_q <= 1'b1;
      end
      if (is_dd) begin
        ac_q <= d[6:0];
        cg_q <= 1'b0;
      end
      if (sh_cur) begin
        ac_q <= ac_next(ac_q, d[B_RL], cfg_q.two_line, cg_q);
      end
      if (sh_dsp) begin
        ofs_q <= ofs_next(ofs_q, ~d[B_RL], cfg_q.two_line);
      end
      if (data_op) begin
        ac_q <= ac_step;
      end
      if (dwr && !cg_q && ash_q) begin
        ofs_q <= ofs_next(ofs_q, incr_q, cfg_q.two_line);
      end
    end
  end

  // read prefetch, loaded one cycle after the counter moves
  always_ff @(posedge mclk) begin
    if (srst) begin
      pf_q    <= 8'h00;
      pf_ld_q <= 1'b0;
    end else begin
      pf_ld_q <= is_cg | is_dd | (sh_cur & ~cg_q) | drd;
      if (pf_ld_q) begin
        pf_q <= cg_q ? cg_rd : dd_rd;
      end
    end
  end

  // blink phase timer
  always_ff @(posedge mclk) begin
    if (srst || !cfg_q.blink_on) begin
      blk_cnt_q <= '0;
      blk_q     <= 1'b0;
    end else if (blk_cnt_q == 32'(BLINK_CYC - 1)) begin
      blk_cnt_q <= '0;
      blk_q     <= ~blk_q;
    end else begin
      blk_cnt_q <= blk_cnt_q + 1'b1;
    end
  end

  // panel facing state
  assign cfg                = cfg_q;
  assign shift_ofs          = ofs_q;
  assign cursor_addr        = ac_q;
  assign cursor_solid       = blk_q;
  assign glyph_sel          = cg_q;
  assign internal_busy_flag = ~idle;

  // clear homes the counter and forces increment
  a_clear_home: assert property (@(posedge mclk) disable iff (srst)
    is_clr |=> ac_q == AC_HOME && incr_q && ofs_q == AC_HOME && filling)
    else $error("clear did not home");
  // home removes the display shift
  a_home_ofs: assert property (@(posedge mclk) disable iff (srst)
    is_home |=> ac_q == AC_HOME && ofs_q == AC_HOME && !filling)
    else $error("home did not reset shift");
  // one-line write increments counter
  a_write_step: assert property (@(posedge mclk) disable iff (srst)
    dwr && incr_q && !cg_q && !cfg_q.two_line && ac_q != L1_LAST
    |=> ac_q == 7'($past(ac_q) + 7'h01))
    else $error("counter did not step up");
  // no display shift on a data access without auto shift
  a_no_shift: assert property (@(posedge mclk) disable iff (srst)
    (dwr || drd) && !ash_q |=> $stable(ofs_q))
    else $error("display shifted without auto shift");
  // display shift keeps the counter
  a_dshift_ac: assert property (@(posedge mclk) disable iff (srst)
    sh_dsp |=> $stable(ac_q) && $changed(ofs_q))
    else $error("display shift moved counter");
  // two-line wrap from first to second line
  a_line_wrap: assert property (@(posedge mclk) disable iff (srst)
    dwr && incr_q && !cg_q && cfg_q.two_line && ac_q == L2A_LAST
    |=> ac_q == L2B_FIRST)
    else $error("no wrap to second line");
  // glyph address set loads six bits and selects glyph RAM
  a_cg_set: assert property (@(posedge mclk) disable iff (srst)
    is_cg |=> ac_q == {1'b0, $past(d[5:0])} && cg_q)
    else $error("glyph address not loaded");
  // busy held after an accepted instruction
  a_busy_hold: assert property (@(posedge mclk) disable iff (srst)
    any_op |=> internal_busy_flag [*8])
    else $error("busy dropped early");
  // write leaves the prefetch alone
  a_pf_keep: assert property (@(posedge mclk) disable iff (srst)
    dwr |=> ##1 $stable(pf_q))
    else $error("write reloaded prefetch");
endmodule : ced_engine
`default_nettype wire

// file: rtl/ced_pkg.sv
// constants and types of the character display instruction engine
package ced_pkg;
  // timing
  localparam int CLK_NS   = 10;
  localparam int CLR_NS   = 1530000;
  localparam int INS_NS   = 39000;
  localparam int DAT_NS   = 43000;
  localparam int BLINK_NS = 400000000;

  // least time in whole cycles, never below one
  function automatic int ced_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ced_cyc

  localparam int INS_CYC = ced_cyc(INS_NS);
  localparam int BW      = 18;

  // memory sizes
  localparam int DD_AW = 7;
  localparam int CG_AW = 6;

  // codes and address limits
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] AC_HOME    = 7'h00;
  localparam logic [6:0] L1_LAST    = 7'h4F;
  localparam logic [6:0] L2A_LAST   = 7'h27;
  localparam logic [6:0] L2B_FIRST  = 7'h40;
  localparam logic [6:0] L2B_LAST   = 7'h67;
  localparam logic [6:0] FILL_LAST  = 7'h7F;
  localparam logic [5:0] CG_LAST    = 6'h3F;

  // instruction field positions
  localparam int B_ID = 1;
  localparam int B_SH = 0;
  localparam int B_D  = 2;
  localparam int B_C  = 1;
  localparam int B_B  = 0;
  localparam int B_SC = 3;
  localparam int B_RL = 2;
  localparam int B_DL = 4;
  localparam int B_N  = 3;
  localparam int B_F  = 2;

  typedef struct packed {
    logic       rs;
    logic [7:0] data;
  } ced_xfer_t;

  typedef struct packed {
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic font_5x11;
    logic two_line;
    logic bus_width_select;
  } ced_cfg_t;

  // reset configuration: 8-bit bus, everything else off
  localparam ced_cfg_t CFG_RST = 6'h01;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_FILL = 2'b11
  } ced_state_t;
endpackage : ced_pkg

// file: rtl/ced_port.sv
// host pin synchroniser, nibble pairing and read drive
`timescale 1ns/100ps
`default_nettype none
module ced_port
  import ced_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // host pins
  input  wire logic       register_select_line,
  input  wire logic       rw,
  input  wire logic       en,
  input  wire logic [7:0] db_i,
  output logic      [7:0] db_o,
  output logic            db_oe_n,
  // mode and read sources
  input  wire logic       bus8,
  input  wire logic [7:0] stat_byte,
  input  wire logic [7:0] data_byte,
  // completed transfers
  output logic            xfer_v,
  output ced_xfer_t       xfer,
  output logic            rd_v,
  output logic            rd_rs
);
  logic [10:0] pin_m_q;
  logic [10:0] pin_s_q;
  logic        en_prev_q;
  logic        nib_q;
  logic [3:0]  hi_q;
  logic [7:0]  db_o_q;
  wire         rs_s = pin_s_q[10];
  wire         rw_s = pin_s_q[9];
  wire         en_s = pin_s_q[8];
  wire  [7:0]  db_s = pin_s_q[7:0];
  wire         fall = en_prev_q & ~en_s;
  wire         done = fall & (bus8 | nib_q);
  wire  [7:0]  byte_in = bus8 ? db_s : {hi_q, db_s[7:4]};
  wire  [7:0]  rd_byte = rs_s ? data_byte : stat_byte;

  // two-stage synchroniser on every pin
  always_ff @(posedge mclk) begin
    pin_m_q <= {register_select_line, rw, en, db_i};
    pin_s_q <= pin_m_q;
  end

  // strobe edge, nibble pairing, completed transfer pulses
  always_ff @(posedge mclk) begin
    if (srst) begin
      en_prev_q <= 1'b0;
      nib_q     <= 1'b0;
      hi_q      <= 4'h0;
      xfer_v    <= 1'b0;
      xfer      <= '0;
      rd_v      <= 1'b0;
      rd_rs     <= 1'b0;
    end else begin
      en_prev_q <= en_s;
      xfer_v    <= done & ~rw_s;
      rd_v      <= done & rw_s;
      if (done) begin
        xfer  <= '{rs: rs_s, data: byte_in};
        rd_rs <= rs_s;
      end
      if (bus8) begin
        nib_q <= 1'b0;
      end else if (fall) begin
        nib_q <= ~nib_q; // upper nibble first
        if (!nib_q) begin
          hi_q <= db_s[7:4];
        end
      end
    end
  end

  // read data on the upper lines in 4-bit mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      db_o_q <= 8'h00;
    end else if (bus8) begin
      db_o_q <= rd_byte;
    end else begin
      db_o_q <= nib_q ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0};
    end
  end

  assign db_o    = db_o_q;
  assign db_oe_n = ~(en_s & rw_s);
endmodule : ced_port
`default_nettype wire

// file: rtl/ced_ram.sv
// flip-flop storage with one write port and two read ports
`timescale 1ns/100ps
`default_nettype none
module ced_ram
  import ced_pkg::*;
#(
  parameter int AW = 7
) (
  // clock
  input  wire logic          mclk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] wa,
  input  wire logic [7:0]    wd,
  // read ports
  input  wire logic [AW-1:0] ra0,
  output logic      [7:0]    rd0,
  input  wire logic [AW-1:0] ra1,
  output logic      [7:0]    rd1
);
  logic [7:0] mem_q [2**AW];

  // reads are combinational
  assign rd0 = mem_q[ra0];
  assign rd1 = mem_q[ra1];

  // store on write strobe
  always_ff @(posedge mclk) begin
    if (we) begin
      mem_q[wa] <= wd;
    end
  end
endmodule : ced_ram
`default_nettype wire

// file: test/ced_engine_tb_top.sv
// self-checking bench of the instruction engine with a host model
`timescale 1ns/100ps
`default_nettype none
module ced_engine_tb_top;
  import ced_pkg::*;

  `define CHK(nm, ex, got) \
    begin \
      n_checks++; \
      if ((got) !== (ex)) begin \
        n_fail++; \
        $display("Error %s expected %h seen %h", nm, ex, got); \
      end \
    end

  typedef struct packed {
    logic [7:0] ins;
    logic [6:0] ac;
    logic [5:0] cf;
    logic       gs;
    logic       shz;
  } ced_row_t;

  // instruction, counter, config, glyph select, shift expected zero
  localparam ced_row_t ROWS [9] = '{
    '{8'h0B, 7'h00, 6'h19, 1'b0, 1'b1}, '{8'h38, 7'h00, 6'h1B, 1'b0, 1'b1},
    '{8'hA5, 7'h25, 6'h1B, 1'b0, 1'b1}, '{8'h14, 7'h26, 6'h1B, 1'b0, 1'b1},
    '{8'h10, 7'h25, 6'h1B, 1'b0, 1'b1}, '{8'h18, 7'h25, 6'h1B, 1'b0, 1'b0},
    '{8'h1C, 7'h25, 6'h1B, 1'b0, 1'b1}, '{8'h7F, 7'h3F, 6'h1B, 1'b1, 1'b1},
    '{8'h0F, 7'h3F, 6'h3B, 1'b1, 1'b1}};

  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       rs, rw, en, hdrv, hang, db_oe_n, cursor_solid;
  logic       glyph_sel, internal_busy_flag;
  logic [7:0] hd, db_o, bus, scan_char, glyph_row, q;
  logic [7:0] lastv = 8'h00;
  logic [6:0] scan_addr = 7'h00;
  logic [5:0] glyph_addr = 6'h00;
  logic [6:0] shift_ofs, cursor_addr, s;
  ced_cfg_t   cfg;
  int         n_fail = 0;
  int         n_checks = 0;
  int         bcnt = 0;
  int         blen = 0;
  logic       hi, lo;

  always #5 mclk = ~mclk;

  // data wire: device when enabled, else host, else a changing pattern
  assign bus = !db_oe_n ? db_o : (hdrv ? hd : ~lastv);
  always @(posedge mclk) lastv <= bus;

  // length of the last busy interval in cycles
  always @(posedge mclk) begin
    if (internal_busy_flag === 1'b1) begin
      bcnt <= bcnt + 1;
    end else if (bcnt != 0) begin
      blen <= bcnt;
      bcnt <= 0;
    end
  end

  ced_host ced_host_inst (.mclk(mclk), .rs(rs), .rw(rw), .en(en), .hd(hd),
    .hdrv(hdrv), .bus(bus), .hang(hang));

  ced_engine #(.CLR_CYC(300), .DAT_CYC(20), .BLINK_CYC(8)) ced_engine_inst (
    .mclk(mclk), .srst(srst), .register_select_line(rs), .rw(rw), .en(en),
    .db_i(bus), .db_o(db_o), .db_oe_n(db_oe_n), .scan_addr(scan_addr),
    .scan_char(scan_char), .glyph_addr(glyph_addr), .glyph_row(glyph_row),
    .cfg(cfg), .shift_ofs(shift_ofs), .cursor_addr(cursor_addr),
    .cursor_solid(cursor_solid), .glyph_sel(glyph_sel),
    .internal_busy_flag(internal_busy_flag));

  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // write then wait for idle
  task automatic cmd(input logic r, input logic nib, input logic [7:0] d);
    logic [7:0] t;
    ced_host_inst.xfer(r, 1'b0, nib, d, t);
    ced_host_inst.wait_idle(nib, t);
  endtask : cmd

  // data read then wait for idle
  task automatic rd(output logic [7:0] d);
    logic [7:0] t;
    ced_host_inst.xfer(1'b1, 1'b1, 1'b0, 8'h00, d);
    ced_host_inst.wait_idle(1'b0, t);
  endtask : rd

  function automatic logic len_ok(input int c);
    return (blen >= c - 1) && (blen <= c + 1);
  endfunction : len_ok

  // a hang in polling or an overall limit closes the run
  always @(posedge hang) begin
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (99000) @(posedge mclk);
    n_fail++;
    $display("Error overall time limit");
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge mclk);
    #1 srst = 1'b0;
    `CHK("cfg", CFG_RST, cfg);
    `CHK("ac", 7'h00, cursor_addr);
    `CHK("shift", 7'h00, shift_ofs);
    `CHK("busy", 1'b0, internal_busy_flag);
    `CHK("oe", 1'b1, db_oe_n);
    $display("test reset done");
    // ordinary instructions from the table
    foreach (ROWS[i]) begin
      cmd(1'b0, 1'b0, ROWS[i].ins);
      `CHK("ac", ROWS[i].ac, cursor_addr);
      `CHK("cfg", ROWS[i].cf, cfg);
      `CHK("gsel", ROWS[i].gs, glyph_sel);
      `CHK("shz", ROWS[i].shz, (shift_ofs === 7'h00));
      `CHK("busy len", 1'b1, len_ok(INS_CYC));
    end
    $display("test table done");
    hi = 1'b0;
    lo = 1'b0;
    repeat (24) begin
      @(posedge mclk) #1;
      hi = hi | (cursor_solid === 1'b1);
      lo = lo | (cursor_solid === 1'b0);
    end
    `CHK("blink", 1'b1, hi & lo);
    $display("test blink done");
    // glyph write at the top address, busy seen by an early status read
    ced_host_inst.xfer(1'b1, 1'b0, 1'b0, 8'h1F, q);
    ced_host_inst.xfer(1'b0, 1'b1, 1'b0, 8'h00, q);
    `CHK("busy bit", 1'b1, q[7]);
    ced_host_inst.wait_idle(1'b0, q);
    `CHK("status", 8'h00, q);
    `CHK("busy len", 1'b1, len_ok(20));
    glyph_addr = 6'h3F;
    #1 `CHK("glyph", 8'h1F, glyph_row);
    $display("test glyph done");
    // two-line wrap forward and back
    cmd(1'b0, 1'b0, 8'hA7);
    cmd(1'b1, 1'b0, 8'h41);
    `CHK("ac", 7'h40, cursor_addr);
    cmd(1'b0, 1'b0, 8'h04);
    cmd(1'b1, 1'b0, 8'h42);
    `CHK("ac", 7'h27, cursor_addr);
    scan_addr = 7'h27;
    #1 `CHK("text", 8'h41, scan_char);
    scan_addr = 7'h40;
    #1 `CHK("text", 8'h42, scan_char);
    $display("test wrap done");
    // auto shift on text writes only, then home
    cmd(1'b0, 1'b0, 8'h07);
    cmd(1'b1, 1'b0, 8'h43);
    `CHK("shifted", 1'b0, (shift_ofs === 7'h00));
    s = shift_ofs;
    cmd(1'b0, 1'b0, 8'h40);
    cmd(1'b1, 1'b0, 8'h0E);
    `CHK("shift", s, shift_ofs);
    cmd(1'b0, 1'b0, 8'h02);
    `CHK("shift", 7'h00, shift_ofs);
    `CHK("ac", 7'h00, cursor_addr);
    `CHK("gsel", 1'b0, glyph_sel);
    `CHK("busy len", 1'b1, len_ok(300));
    #1 `CHK("text", 8'h42, scan_char);
    $display("test shift done");
    // clear with decrement selected beforehand
    cmd(1'b0, 1'b0, 8'h04);
    cmd(1'b0, 1'b0, 8'h01);
    `CHK("busy len", 1'b1, len_ok(300));
    `CHK("ac", 7'h00, cursor_addr);
    #1 `CHK("text", 8'h20, scan_char);
    cmd(1'b1, 1'b0, 8'h44);
    `CHK("ac", 7'h01, cursor_addr);
    $display("test clear done");
    // one-line mode keeps 27H and 28H contiguous
    cmd(1'b0, 1'b0, 8'h30);
    `CHK("cfg", 6'h39, cfg);
    cmd(1'b0, 1'b0, 8'hA7);
    cmd(1'b1, 1'b0, 8'h45);
    `CHK("ac", 7'h28, cursor_addr);
    $display("test one line done");
    // prefetch: address set before reading, write then stale read
    cmd(1'b0, 1'b0, 8'h87);
    cmd(1'b1, 1'b0, 8'h52);
    cmd(1'b0, 1'b0, 8'h85);
    rd(q);
    `CHK("read", 8'h20, q);
    `CHK("ac", 7'h06, cursor_addr);
    cmd(1'b1, 1'b0, 8'h53);
    rd(q);
    `CHK("read", 8'h20, q);
    $display("test read done");
    // 4-bit bus: address set and status in nibbles, then back to 8-bit
    // the switch lands mid-sequence, so polls already go in nibble pairs
    ced_host_inst.xfer(1'b0, 1'b0, 1'b0, 8'h28, q);
    ced_host_inst.wait_idle(1'b1, q);
    `CHK("cfg", 6'h3A, cfg);
    cmd(1'b0, 1'b1, 8'hC1);
    `CHK("ac", 7'h41, cursor_addr);
    ced_host_inst.wait_idle(1'b1, q);
    `CHK("status", 8'h41, q);
    cmd(1'b0, 1'b1, 8'h3C);
    `CHK("cfg", 6'h3F, cfg);
    ced_host_inst.wait_idle(1'b0, q);
    `CHK("status", 8'h41, q);
    $display("test nibble done");
    wrap_up();
  end

  `undef CHK
endmodule : ced_engine_tb_top
`default_nettype wire

// file: test/ced_host.sv
// host processor model driving the parallel instruction and data port
`timescale 1ns/100ps
`default_nettype none
module ced_host (
  // clock
  input  wire logic       mclk,
  // host pins
  output logic            rs,
  output logic            rw,
  output logic            en,
  output logic      [7:0] hd,
  output logic            hdrv,
  input  wire logic [7:0] bus,
  // poll limit reached
  output logic            hang
);
  initial begin
    rs = 1'b0;
    rw = 1'b0;
    en = 1'b0;
    hd = 8'h00;
    hdrv = 1'b0;
    hang = 1'b0;
  end

  // one strobe: pins held from setup until well after the fall of en
  task automatic strobe(input logic r, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge mclk) #1;
    rs = r;
    rw = w;
    hd = d;
    hdrv = ~w;
    @(posedge mclk) #1;
    en = 1'b1;
    repeat (7) @(posedge mclk);
    #1;
    q = bus;
    en = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    hdrv = 1'b0;
  endtask : strobe

  // one byte; in 4-bit mode two strobes, upper nibble on db[7:4] first
  task automatic xfer(input logic r, input logic w, input logic nib,
                      input logic [7:0] d, output logic [7:0] q);
    logic [7:0] a;
    logic [7:0] b;
    if (nib) begin
      strobe(r, w, d, a);
      strobe(r, w, {d[3:0], d[7:4]}, b);
      q = {a[7:4], b[7:4]};
    end else begin
      strobe(r, w, d, q);
    end
  endtask : xfer

  // status reads until the busy bit is low, under a bound
  task automatic wait_idle(input logic nib, output logic [7:0] st);
    int k;
    k = 0;
    xfer(1'b0, 1'b1, nib, 8'h00, st);
    while (st[7] !== 1'b0 && k < 400) begin
      xfer(1'b0, 1'b1, nib, 8'h00, st);
      k++;
    end
    if (k >= 400) begin
      hang = 1'b1;
    end
  endtask : wait_idle
endmodule : ced_host
`default_nettype wire
